//--- hw/dim_ctrl_pkg.sv
// Contract
// - First rise enables, all currents stay zero
// - First falling edge sets level 31 mA
// - Each later falling edge lowers one mA
// - Thirty-second counted pulse reaches zero level
// - Pulse at zero wraps level to 31
// - Low for 1.5 ms enters shutdown
// - Pulse rates 5 kHz to 1 MHz counted
// - One level drives all four channels together
// - Undervoltage disables every LED channel
// - Shutdown puts channels high impedance, zero current
// - Pump starts 1x, stays while regulating
// - Switch to 1.5x after 400 us delay
// - Mode sequence restarts on power-up, shutdown exit
`default_nettype none

package dim_ctrl_pkg;

  localparam int         CHANNELS     = 4;
  localparam int         LEVEL_W      = 5;
  localparam logic [4:0] LEVEL_FULL   = 5'h1f;
  localparam logic [4:0] LEVEL_STEP   = 5'h01;
  localparam logic [4:0] LEVEL_ZERO   = 5'h00;
  localparam logic [4:0] LEVEL_RESET  = 5'h00;

  localparam int CLK_PERIOD_NS  = 8;
  localparam int T_OFF_NS       = 1500000;
  localparam int T_PUMP_NS      = 400000;
  localparam int T_OFF_CYCLES   = T_OFF_NS / CLK_PERIOD_NS;
  localparam int T_PUMP_CYCLES  = T_PUMP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_SHUTDOWN = 2'b00,
    ST_ARMED    = 2'b01,
    ST_DIMMING  = 2'b10
  } state_t;

  // Pins that arrive from outside the clock domain
  typedef struct packed {
    logic en;
    logic uv;
    logic reg_lost;
  } pin_t;

  localparam pin_t PIN_RESET = 3'h0;

  typedef struct packed {
    pin_t s1;
    pin_t s2;
    pin_t s3;
    pin_t level;
  } sync_t;

  typedef struct packed {
    state_t                state;
    logic [LEVEL_W-1:0]    level;
    logic                  unpulsed;
    logic                  pump_1p5x;
    logic                  en_prev;
    logic                  enabled;
    logic [CHANNELS-1:0]   sink_on;
    logic [CHANNELS-1:0]   hiz;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{
    state:     ST_SHUTDOWN,
    level:     LEVEL_RESET,
    unpulsed:  1'b1,
    pump_1p5x: 1'b0,
    en_prev:   1'b0,
    enabled:   1'b0,
    sink_on:   4'h0,
    hiz:       4'hf
  };

endpackage

`default_nettype wire

//--- hw/led_dim_ctrl.sv
`default_nettype none

module led_dim_ctrl
  import dim_ctrl_pkg::*;
#(
  parameter int OFF_CYCLES  = T_OFF_CYCLES,
  parameter int PUMP_CYCLES = T_PUMP_CYCLES
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  input  wire logic                i_enable_dim_input,
  input  wire logic                i_supply_uv,
  input  wire logic                i_pump_reg_lost,
  output logic [LEVEL_W-1:0]       o_led_level,
  output logic [CHANNELS-1:0]      o_led_sink_on,
  output logic [CHANNELS-1:0]      o_led_sink_hiz,
  output logic                     o_pump_1p5x,
  output logic                     o_enabled,
  output logic                     o_shutdown
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and timers

  pin_t  pins_raw;
  pin_t  pins;
  logic  off_done;
  logic  pump_done;
  logic  en_rise;
  logic  en_fall;
  logic  pump_run;
  ctrl_t ff;
  ctrl_t nxt_ff;

  assign pins_raw = '{en: i_enable_dim_input, uv: i_supply_uv, reg_lost: i_pump_reg_lost};

  pin_sync u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pins  (pins_raw),
    .o_level (pins)
  );

  // Low time measured, restarted by any return high
  run_timer #(
    .CYCLES (OFF_CYCLES)
  ) u_off_timer (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_run   (!pins.en),
    .o_done  (off_done)
  );

  // Continuous loss of regulation while still in 1x
  assign pump_run = ff.enabled && !ff.pump_1p5x && pins.reg_lost && !pins.uv;

  run_timer #(
    .CYCLES (PUMP_CYCLES)
  ) u_pump_timer (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_run   (pump_run),
    .o_done  (pump_done)
  );

  assign en_rise = pins.en && !ff.en_prev;
  assign en_fall = !pins.en && ff.en_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Control state

  // Any state that may drive the channels
  function automatic logic is_awake(input state_t s);
    return s != ST_SHUTDOWN;
  endfunction

  always_comb
  begin
    nxt_ff         = ff;
    nxt_ff.en_prev = pins.en;
    case (ff.state)
      ST_SHUTDOWN:
      begin
        if (en_rise)
        begin
          nxt_ff.state     = ST_ARMED;
          nxt_ff.level     = LEVEL_ZERO;
          nxt_ff.unpulsed  = 1'b1;
          nxt_ff.pump_1p5x = 1'b0;
        end
      end
      ST_ARMED:
      begin
        if (en_fall && !pins.uv)
        begin
          nxt_ff.state    = ST_DIMMING;
          nxt_ff.level    = LEVEL_FULL;
          nxt_ff.unpulsed = 1'b0;
        end
      end
      ST_DIMMING:
      begin
        if (en_fall && !pins.uv)
        begin
          if (ff.level == LEVEL_ZERO)
          begin
            nxt_ff.level = LEVEL_FULL;
          end
          else
          begin
            nxt_ff.level = ff.level - LEVEL_STEP;
          end
        end
      end
      default:
      begin
        nxt_ff.state = ST_SHUTDOWN;
      end
    endcase

    // Undervoltage drops back to the unpulsed zero state
    if (pins.uv && is_awake(ff.state))
    begin
      nxt_ff.state     = ST_ARMED;
      nxt_ff.level     = LEVEL_ZERO;
      nxt_ff.unpulsed  = 1'b1;
      nxt_ff.pump_1p5x = 1'b0;
    end

    if (off_done && is_awake(ff.state))
    begin
      nxt_ff.state     = ST_SHUTDOWN;
      nxt_ff.level     = LEVEL_ZERO;
      nxt_ff.unpulsed  = 1'b1;
      nxt_ff.pump_1p5x = 1'b0;
    end

    // Pump leaves 1x only after the fixed delay
    if (pump_done && pins.reg_lost && is_awake(ff.state) && !pins.uv && !off_done)
    begin
      nxt_ff.pump_1p5x = 1'b1;
    end

    nxt_ff.enabled = is_awake(nxt_ff.state);
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      nxt_ff.sink_on[ch] = nxt_ff.enabled && !pins.uv && (nxt_ff.level != LEVEL_ZERO);
      nxt_ff.hiz[ch]     = !nxt_ff.enabled;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      ff <= CTRL_RESET;
    end
    else
    begin
      ff <= nxt_ff;
    end
  end

  assign o_led_level    = ff.level;
  assign o_led_sink_on  = ff.sink_on;
  assign o_led_sink_hiz = ff.hiz;
  assign o_pump_1p5x    = ff.pump_1p5x;
  assign o_enabled      = ff.enabled;
  assign o_shutdown     = ff.hiz[0];

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers

  logic [5:0]  fall_cnt_ff;
  logic [31:0] low_cnt_ff;
  logic [31:0] lost_cnt_ff;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      fall_cnt_ff <= 6'h00;
      low_cnt_ff  <= 32'h0;
      lost_cnt_ff <= 32'h0;
    end
    else
    begin
      if (!is_awake(ff.state) || pins.uv)
      begin
        fall_cnt_ff <= 6'h00;
      end
      else if (en_fall)
      begin
        fall_cnt_ff <= fall_cnt_ff + 6'h01;
      end
      low_cnt_ff  <= pins.en ? 32'h0 : low_cnt_ff + 32'h1;
      lost_cnt_ff <= pump_run ? lost_cnt_ff + 32'h1 : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_wake;
    ff.state == ST_SHUTDOWN && en_rise && !off_done;
  endsequence

  sequence s_count_fall;
    en_fall && !pins.uv && !off_done;
  endsequence

  sequence s_uv_hold;
    pins.uv ##1 pins.uv;
  endsequence

  a_wake_zero_level: assert property (
    s_wake |=> o_enabled && o_led_level == 5'h00 && o_led_sink_on == 4'h0)
    else $error("Enable did not start at zero current");

  a_first_fall_full: assert property (
    (ff.state == ST_ARMED) and s_count_fall |=> o_led_level == 5'h1f && !ff.unpulsed)
    else $error("First pulse did not set full scale");

  a_step_one_ma: assert property (
    (ff.state == ST_DIMMING && ff.level != 5'h00) and s_count_fall
    |=> o_led_level == $past(ff.level) - 5'h01)
    else $error("Falling edge did not step down one level");

  a_pulse32_zero: assert property (
    fall_cnt_ff == 6'h20 && ff.state == ST_DIMMING |-> o_led_level == 5'h00)
    else $error("Thirty-second pulse did not reach zero");

  a_zero_wraps_full: assert property (
    (ff.state == ST_DIMMING && ff.level == 5'h00) and s_count_fall |=> o_led_level == 5'h1f)
    else $error("Pulse at zero did not wrap to full scale");

  a_low_shutdown: assert property (
    low_cnt_ff > 32'(OFF_CYCLES + 4) |-> o_shutdown && o_led_level == 5'h00)
    else $error("Long low did not enter shutdown");

  a_short_low_stays: assert property (
    o_enabled && low_cnt_ff < 32'(OFF_CYCLES - 1) && !pins.uv |=> o_enabled)
    else $error("Short low left enabled state");

  a_channels_equal: assert property (
    o_led_sink_on == {CHANNELS{o_led_sink_on[0]}} && o_led_sink_hiz == {CHANNELS{o_led_sink_hiz[0]}})
    else $error("Channels differ");

  a_uv_disables: assert property (
    s_uv_hold |-> o_led_sink_on == 4'h0 && o_led_level == 5'h00)
    else $error("Undervoltage left a channel on");

  a_shutdown_hiz: assert property (
    !o_enabled |-> o_shutdown && o_led_sink_hiz == 4'hf && o_led_sink_on == 4'h0)
    else $error("Shutdown channel not high impedance");

  a_wake_pump_1x: assert property (
    s_wake |=> !o_pump_1p5x)
    else $error("Pump not back in 1x after wake");

  a_pump_delay: assert property (
    $rose(o_pump_1p5x) |-> $past(lost_cnt_ff) >= 32'(PUMP_CYCLES))
    else $error("Pump moved to 1.5x before the delay");

  a_pump_stays_1x: assert property (
    !o_pump_1p5x && !pins.reg_lost |=> !o_pump_1p5x)
    else $error("Pump left 1x while regulating");

  a_off_clears_state: assert property (
    ff.state != ST_SHUTDOWN && off_done |=> o_shutdown && o_led_level == 5'h00 && ff.unpulsed && !o_pump_1p5x)
    else $error("Shutdown did not clear level and flag");

  a_uv_clears_flag: assert property (
    pins.uv && ff.state != ST_SHUTDOWN |=> ff.unpulsed && o_led_level == 5'h00 && !o_pump_1p5x)
    else $error("Undervoltage did not clear level and flag");

  a_armed_zero_level: assert property (
    ff.state == ST_ARMED |-> o_led_level == 5'h00 && o_led_sink_on == 4'h0)
    else $error("Current flowed before the first pulse");

  a_level_sinks_on: assert property (
    o_enabled && o_led_level != 5'h00 |-> o_led_sink_on == 4'hf)
    else $error("Nonzero level left a channel off");

  a_level_holds: assert property (
    ff.state == ST_DIMMING && !en_fall && !pins.uv && !off_done |=> $stable(o_led_level))
    else $error("Level changed without a falling edge");

  a_awake_drives: assert property (
    o_enabled |-> o_led_sink_hiz == 4'h0 && !o_shutdown)
    else $error("Enabled channel left high impedance");

  a_wake_hiz_low: assert property (
    s_wake |=> o_led_sink_hiz == 4'h0 && !o_shutdown)
    else $error("Wake did not leave shutdown");

  a_pulse33_full: assert property (
    fall_cnt_ff == 6'h21 && ff.state == ST_DIMMING |-> o_led_level == 5'h1f)
    else $error("Thirty-third pulse did not wrap to full scale");

endmodule

`default_nettype wire

//--- hw/pin_sync.sv
`default_nettype none

module pin_sync
  import dim_ctrl_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire pin_t i_pins,
  output pin_t      o_level
);

  sync_t ff;
  sync_t nxt_ff;

  // Level follows only once stages two and three agree
  always_comb
  begin
    nxt_ff    = ff;
    nxt_ff.s1 = i_pins;
    nxt_ff.s2 = ff.s1;
    nxt_ff.s3 = ff.s2;
    for (int i = 0; i < $bits(pin_t); i++)
    begin
      if (ff.s2[i] == ff.s3[i])
      begin
        nxt_ff.level[i] = ff.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      ff <= '{PIN_RESET, PIN_RESET, PIN_RESET, PIN_RESET};
    end
    else
    begin
      ff <= nxt_ff;
    end
  end

  assign o_level = ff.level;

endmodule

`default_nettype wire

//--- hw/run_timer.sv
`default_nettype none

module run_timer #(
  parameter int CYCLES = 1000
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_run,
  output logic      o_done
);

  localparam int W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } tmr_t;

  tmr_t ff;
  tmr_t nxt_ff;

  // Counts consecutive cycles of i_run; drop of i_run restarts it
  always_comb
  begin
    nxt_ff = ff;
    if (!i_run)
    begin
      nxt_ff.cnt  = '0;
      nxt_ff.done = 1'b0;
    end
    else if (ff.cnt == W'(CYCLES - 1))
    begin
      nxt_ff.done = 1'b1;
    end
    else
    begin
      nxt_ff.cnt = ff.cnt + W'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      ff <= '0;
    end
    else
    begin
      ff <= nxt_ff;
    end
  end

  assign o_done = ff.done;

endmodule

`default_nettype wire

//--- tb/dim_host.sv
`default_nettype none

module dim_host
(
  input  wire logic i_clk,
  output logic      o_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_pin = 1'b0;

  // Holds the pin at one level for a number of clock cycles
  task automatic drive(input logic lvl, input int n);
    o_pin <= lvl;
    repeat (n) @(posedge i_clk);
  endtask

endmodule

`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none

module tb_top
  import dim_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int OFF_C  = 200;
  localparam int PUMP_C = 50;
  localparam int LIMIT  = 40000;

  logic                i_clk;
  logic                i_rst_b;
  logic                pin;
  logic                uv;
  logic                lost;
  logic [LEVEL_W-1:0]  o_led_level;
  logic [CHANNELS-1:0] o_led_sink_on;
  logic [CHANNELS-1:0] o_led_sink_hiz;
  logic                o_pump_1p5x;
  logic                o_enabled;
  logic                o_shutdown;
  int                  fails;
  int                  total_checks;
  int                  cycles;
  int                  lo;
  int                  hi;

  led_dim_ctrl #(
    .OFF_CYCLES  (OFF_C),
    .PUMP_CYCLES (PUMP_C)
  ) dut (
    .i_clk              (i_clk),
    .i_rst_b            (i_rst_b),
    .i_enable_dim_input (pin),
    .i_supply_uv        (uv),
    .i_pump_reg_lost    (lost),
    .o_led_level        (o_led_level),
    .o_led_sink_on      (o_led_sink_on),
    .o_led_sink_hiz     (o_led_sink_hiz),
    .o_pump_1p5x        (o_pump_1p5x),
    .o_enabled          (o_enabled),
    .o_shutdown         (o_shutdown)
  );

  dim_host u_host (
    .i_clk (i_clk),
    .o_pin (pin)
  );

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fails++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Level after n falls since wake
  function automatic logic [4:0] exp_level(input int n);
    return 5'(31 - ((n - 1) % 32));
  endfunction

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check_off();
    check("shutdown", 8'h01, 8'(o_shutdown));
    check("hiz off", 8'h0f, 8'(o_led_sink_hiz));
    check("sink off", 8'h00, 8'(o_led_sink_on));
    check("level off", 8'h00, 8'(o_led_level));
    check("pump off", 8'h00, 8'(o_pump_1p5x));
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    cycles = 0;
    fails = 0;
    total_checks = 0;
    i_rst_b = 1'b0;
    uv = 1'b0;
    lost = 1'b0;
    void'($urandom(85));
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1;
    check_off();
    @(posedge i_clk);
    u_host.drive(1'b1, 1250);
    #1;
    check("enabled", 8'h01, 8'(o_enabled));
    check("wake level", 8'h00, 8'(o_led_level));
    check("wake sink", 8'h00, 8'(o_led_sink_on));
    check("wake hiz", 8'h00, 8'(o_led_sink_hiz));
    for (int n = 1; n <= 34; n++)
    begin
      @(posedge i_clk);
      lo = (n == 2) ? OFF_C - 30 : 40 + int'($urandom % 60);
      hi = 85 + int'($urandom % 40);
      u_host.drive(1'b0, lo);
      u_host.drive(1'b1, hi);
      #1;
      check("level", 8'(exp_level(n)), 8'(o_led_level));
      check("sinks", (exp_level(n) != 0) ? 8'h0f : 8'h00, 8'(o_led_sink_on));
      check("alive", 8'h00, 8'(o_shutdown));
    end
    @(posedge i_clk);
    lost <= 1'b1;
    repeat (40) @(posedge i_clk);
    #1;
    check("pump early", 8'h00, 8'(o_pump_1p5x));
    repeat (30) @(posedge i_clk);
    #1;
    check("pump late", 8'h01, 8'(o_pump_1p5x));
    @(posedge i_clk);
    uv <= 1'b1;
    repeat (8) @(posedge i_clk);
    #1;
    check("uv level", 8'h00, 8'(o_led_level));
    check("uv sink", 8'h00, 8'(o_led_sink_on));
    check("uv pump", 8'h00, 8'(o_pump_1p5x));
    @(posedge i_clk);
    uv <= 1'b0;
    repeat (8) @(posedge i_clk);
    u_host.drive(1'b0, 50);
    u_host.drive(1'b1, 100);
    #1;
    check("uv relevel", 8'h1f, 8'(o_led_level));
    @(posedge i_clk);
    u_host.drive(1'b0, OFF_C + 15);
    #1;
    check_off();
    @(posedge i_clk);
    u_host.drive(1'b1, 20);
    #1;
    check("restart 1x", 8'h00, 8'(o_pump_1p5x));
    check("restart lvl", 8'h00, 8'(o_led_level));
    @(posedge i_clk);
    u_host.drive(1'b1, 60);
    #1;
    check("restart 1p5x", 8'h01, 8'(o_pump_1p5x));
    report_and_stop();
  end

endmodule

`default_nettype wire
